// ---- hw/adcsc_params.svh ----
// Constants of the serial conversion control block: offsets, fields,
// reset values and timing counts. Included by the design files only.
`ifndef ADCSC_PARAMS_SVH
`define ADCSC_PARAMS_SVH

// Register byte offsets
`define ADCSC_CONFIG_OFS   8'h00
`define ADCSC_RESULT_OFS   8'h04
`define ADCSC_STATUS_OFS   8'h08
`define ADCSC_MASK_OFS     8'h0c
`define ADCSC_STATE_OFS    8'h10

// Configuration word fields
`define ADCSC_START_BIT    15
`define ADCSC_CHAN_LSB     12
`define ADCSC_GAIN_LSB     9
`define ADCSC_MODE_BIT     8
`define ADCSC_DR_LSB       5
`define ADCSC_CONFIG_RST   16'h0580

// Status and mask bits
`define ADCSC_ST_DONE      0
`define ADCSC_ST_TMO       1
`define ADCSC_ST_XFER      2

// Serial transfer and result shape
`define ADCSC_XFER_BITS    16
`define ADCSC_CODE_MAX     16'h7fff
`define ADCSC_CODE_MIN     16'h8000

// Timing
`define ADCSC_CLK_HZ       20000000
`define ADCSC_SCLK_TO_MS   28
`define ADCSC_SCLK_TO_CYC  (`ADCSC_SCLK_TO_MS * (`ADCSC_CLK_HZ / 1000))
`define ADCSC_DR0_CYC      (`ADCSC_CLK_HZ / 8)
`define ADCSC_DR1_CYC      (`ADCSC_CLK_HZ / 16)
`define ADCSC_DR2_CYC      (`ADCSC_CLK_HZ / 32)
`define ADCSC_DR3_CYC      (`ADCSC_CLK_HZ / 64)
`define ADCSC_DR4_CYC      (`ADCSC_CLK_HZ / 128)
`define ADCSC_DR5_CYC      (`ADCSC_CLK_HZ / 250)
`define ADCSC_DR6_CYC      (`ADCSC_CLK_HZ / 475)
`define ADCSC_DR7_CYC      (`ADCSC_CLK_HZ / 860)

`endif

// ---- hw/adcsc_pkg.sv ----
// Types shared by the serial conversion control block.
// Assumes the params header is included alongside by each design file.
package adcsc_pkg;

	// Conversion sequencer states
	typedef enum logic [0:0] {
		ADCSC_SHUTDOWN = 1'b0,
		ADCSC_CONVERT  = 1'b1
	} adcsc_seq_t;

endpackage : adcsc_pkg

// ---- hw/adcsc_filter.sv ----
// Decimating filter of the conversion core: sums the modulator bitstream
// over one conversion period and emits a saturated 16-bit code.
// Assumes the modulator bit is sampled on hclk by the analog front end.
`timescale 1ns/1ps
`include "adcsc_params.svh"
module adcsc_filter
	import adcsc_pkg::*;
#(
	parameter int CNT_W = 32
) (
	// Clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// Control
	input  wire logic             start,
	input  wire logic [CNT_W-1:0] period,
	// Modulator stream
	input  wire logic             mod_bit,
	// Result
	output logic                  done,
	output logic [15:0]           code
);

	logic                    busy_r;
	logic [CNT_W-1:0]        cnt_r;
	logic signed [CNT_W-1:0] acc_r;
	logic signed [CNT_W-1:0] acc_nxt;
	logic [15:0]             sat_code;
	logic                    last;

	// One step of the bitstream sum
	assign acc_nxt = mod_bit ? acc_r + 1 : acc_r - 1;
	assign last    = busy_r && (cnt_r == '0);
	// Clip out-of-range sums to full scale
	assign sat_code = (acc_nxt > 32'sd32767)  ? `ADCSC_CODE_MAX :
	                  (acc_nxt < -32'sd32768) ? `ADCSC_CODE_MIN :
	                  acc_nxt[15:0];

	// Period counter and accumulator
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_r <= 1'b0;
			cnt_r  <= '0;
			acc_r  <= '0;
		end else if (start) begin
			busy_r <= 1'b1;
			cnt_r  <= period - 1'b1;
			acc_r  <= '0;
		end else if (busy_r) begin
			busy_r <= !last;
			cnt_r  <= cnt_r - 1'b1;
			acc_r  <= acc_nxt;
		end
	end

	// Result and completion pulse
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done <= 1'b0;
			code <= 16'h0000;
		end else begin
			done <= last && !start;
			if (last && !start) begin
				code <= sat_code;
			end
		end
	end

endmodule : adcsc_filter

// ---- hw/adcsc_top.sv ----
// Digital side of a delta-sigma converter: serial port with combined
// data-out and ready pin, conversion sequencer and AHB-Lite registers.
// Assumes one AHB-Lite master and serial pins from another clock domain.
//
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "adcsc_params.svh"
module adcsc_top
	import adcsc_pkg::*;
#(
	parameter int SCLK_TO_CYC = `ADCSC_SCLK_TO_CYC,
	parameter int DR0_CYC     = `ADCSC_DR0_CYC,
	parameter int DR1_CYC     = `ADCSC_DR1_CYC,
	parameter int DR2_CYC     = `ADCSC_DR2_CYC,
	parameter int DR3_CYC     = `ADCSC_DR3_CYC,
	parameter int DR4_CYC     = `ADCSC_DR4_CYC,
	parameter int DR5_CYC     = `ADCSC_DR5_CYC,
	parameter int DR6_CYC     = `ADCSC_DR6_CYC,
	parameter int DR7_CYC     = `ADCSC_DR7_CYC
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Serial pins
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        din,
	output logic             data_out_ready_n,
	output logic             data_out_oe,
	// Analog front end
	input  wire logic        mod_bit,
	output logic [2:0]       gain_select,
	output logic [2:0]       input_channel_select,
	output logic             power_down,
	// Interrupt
	output logic             irq
);

	localparam int unsigned DR_TAB [0:7] = '{DR0_CYC, DR1_CYC, DR2_CYC,
		DR3_CYC, DR4_CYC, DR5_CYC, DR6_CYC, DR7_CYC};
	localparam logic [4:0] LAST_BIT = 5'(`ADCSC_XFER_BITS - 1);
	// Idle pin levels {din, cs_n, sclk}: deselected, clock parked low,
	// so leaving reset shows no false serial clock edge
	localparam logic [2:0] PIN_IDLE = 3'b010;

	// Pin synchronisers: three stages, filtered level and previous level
	logic [2:0] pin_in;
	logic [2:0] sy1_r;
	logic [2:0] sy2_r;
	logic [2:0] sy3_r;
	logic [2:0] filt_r;
	logic [2:0] filt_nxt;
	logic [2:0] rise;
	logic [2:0] fall;

	// Serial port state
	logic        xfer_act_r;
	logic [4:0]  bit_cnt_r;
	logic [15:0] sh_out_r;
	logic [15:0] sh_in_r;
	logic [15:0] sh_in_nxt;
	logic        dout_r;
	logic        ready_n_r;
	logic [31:0] lo_cnt_r;
	logic        sclk_f;
	logic        cs_n_f;
	logic        din_f;
	logic        sclk_up;
	logic        sclk_dn;
	logic        tmo;
	logic        xfer_begin;
	logic        cfg_load;

	// Configuration, result and sequencer
	logic [15:0] cfg_r;
	logic [15:0] result_r;
	logic        mode_single;
	logic        start_req;
	logic [31:0] dr_cyc;
	logic [2:0]  rate_sel;
	adcsc_seq_t  state_r;
	logic        conv_start;
	logic        conv_done;
	logic [15:0] conv_code;

	// Bus and interrupt state
	logic        addr_ph;
	logic        wr_pend_r;
	logic [7:0]  wr_addr_r;
	logic [31:0] hrdata_r;
	logic [31:0] rd_mux;
	logic [2:0]  status_r;
	logic [2:0]  mask_r;
	logic [2:0]  ev;
	logic        wr_cfg;
	logic        wr_status;
	logic        wr_mask;

	assign pin_in = {din, cs_n, sclk};

	// Per-pin synchroniser; a change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			assign filt_nxt[gi] = (sy2_r[gi] == sy3_r[gi]) ? sy2_r[gi]
			                                              : filt_r[gi];
			assign rise[gi] = filt_nxt[gi] && !filt_r[gi];
			assign fall[gi] = !filt_nxt[gi] && filt_r[gi];
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					sy1_r[gi]  <= PIN_IDLE[gi];
					sy2_r[gi]  <= PIN_IDLE[gi];
					sy3_r[gi]  <= PIN_IDLE[gi];
					filt_r[gi] <= PIN_IDLE[gi];
				end else begin
					sy1_r[gi]  <= pin_in[gi];
					sy2_r[gi]  <= sy1_r[gi];
					sy3_r[gi]  <= sy2_r[gi];
					filt_r[gi] <= filt_nxt[gi];
				end
			end
		end
	endgenerate

	// Filtered pin levels and clock edges, gated by select
	assign sclk_f  = filt_r[0];
	assign cs_n_f  = filt_r[1];
	assign din_f   = filt_nxt[2];
	assign sclk_up = rise[0] && !cs_n_f;
	assign sclk_dn = fall[0] && !cs_n_f;
	// A rising edge in the limit cycle is a clock edge, not a timeout
	assign tmo     = !sclk_f && !rise[0]
	                 && (lo_cnt_r >= 32'(SCLK_TO_CYC));
	assign xfer_begin = sclk_up && !xfer_act_r && !tmo;
	assign sh_in_nxt  = {sh_in_r[14:0], din_f};
	assign cfg_load   = sclk_dn && xfer_act_r && !tmo
	                    && (bit_cnt_r == LAST_BIT);

	// Time that the serial clock has stayed low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lo_cnt_r <= '0;
		end else if (sclk_f || tmo) begin
			lo_cnt_r <= '0;
		end else begin
			lo_cnt_r <= lo_cnt_r + 1'b1;
		end
	end

	// Transfer framing and bit count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xfer_act_r <= 1'b0;
			bit_cnt_r  <= '0;
		end else if (cs_n_f || tmo) begin
			xfer_act_r <= 1'b0;
			bit_cnt_r  <= '0;
		end else if (xfer_begin) begin
			xfer_act_r <= 1'b1;
			bit_cnt_r  <= '0;
		end else if (sclk_dn && xfer_act_r) begin
			xfer_act_r <= !cfg_load;
			bit_cnt_r  <= bit_cnt_r + 1'b1;
		end
	end

	// Shift registers: result out MSB first, configuration in
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sh_out_r <= '0;
			sh_in_r  <= '0;
			dout_r   <= 1'b1;
		end else begin
			if (xfer_begin) begin
				dout_r   <= result_r[15];
				sh_out_r <= {result_r[14:0], 1'b0};
			end else if (sclk_up && xfer_act_r) begin
				dout_r   <= sh_out_r[15];
				sh_out_r <= {sh_out_r[14:0], 1'b0};
			end
			if (sclk_dn && xfer_act_r) begin
				sh_in_r <= sh_in_nxt;
			end
		end
	end

	// Ready flag: low on a new result, high once reading begins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ready_n_r <= 1'b1;
		end else if (conv_done) begin
			ready_n_r <= 1'b0;
		end else if (xfer_begin) begin
			ready_n_r <= 1'b1;
		end
	end

	// Shared pin: data during a transfer, ready flag while selected otherwise, high when deselected
	assign data_out_oe      = !cs_n_f;
	assign data_out_ready_n = cs_n_f ? 1'b1 :
	                          (xfer_act_r ? dout_r : ready_n_r);

	// Bus decode
	assign addr_ph   = hsel && hready && htrans[1];
	assign wr_cfg    = wr_pend_r && (wr_addr_r == `ADCSC_CONFIG_OFS);
	assign wr_status = wr_pend_r && (wr_addr_r == `ADCSC_STATUS_OFS);
	assign wr_mask   = wr_pend_r && (wr_addr_r == `ADCSC_MASK_OFS);
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_r;

	// Read selection; unmapped offsets read zero
	assign rd_mux = (haddr[7:0] == `ADCSC_CONFIG_OFS) ? {16'h0000, cfg_r} :
	                (haddr[7:0] == `ADCSC_RESULT_OFS) ? {16'h0000, result_r} :
	                (haddr[7:0] == `ADCSC_STATUS_OFS) ? {29'h0, status_r} :
	                (haddr[7:0] == `ADCSC_MASK_OFS)   ? {29'h0, mask_r} :
	                (haddr[7:0] == `ADCSC_STATE_OFS)  ?
	                {28'h0, xfer_act_r, ready_n_r, power_down,
	                 state_r == ADCSC_CONVERT} : 32'h0000_0000;

	// Address phase capture and registered read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
			hrdata_r  <= '0;
		end else begin
			wr_pend_r <= addr_ph && hwrite;
			if (addr_ph) begin
				wr_addr_r <= haddr[7:0];
			end
			if (addr_ph && !hwrite) begin
				hrdata_r <= rd_mux;
			end
		end
	end

	// Conversion requests from either the bus or the serial port
	assign start_req = (wr_cfg && hwdata[`ADCSC_START_BIT])
	                   || (cfg_load && sh_in_nxt[`ADCSC_START_BIT]);
	assign mode_single = cfg_r[`ADCSC_MODE_BIT];

	// Configuration word; a serial load wins over a bus write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_r <= `ADCSC_CONFIG_RST;
		end else if (cfg_load) begin
			cfg_r <= {1'b0, sh_in_nxt[14:0]};
		end else if (wr_cfg) begin
			cfg_r <= {1'b0, hwdata[14:0]};
		end
	end

	// Front-end selects straight from the configuration word
	assign gain_select          = cfg_r[`ADCSC_GAIN_LSB +: 3];
	assign input_channel_select = cfg_r[`ADCSC_CHAN_LSB +: 3];
	// A starting write or serial load brings its own data rate
	assign rate_sel = cfg_load ? sh_in_nxt[`ADCSC_DR_LSB +: 3] :
	                  wr_cfg   ? hwdata[`ADCSC_DR_LSB +: 3] :
	                  cfg_r[`ADCSC_DR_LSB +: 3];
	assign dr_cyc = 32'(DR_TAB[rate_sel]);
	assign power_down = (state_r == ADCSC_SHUTDOWN);

	// Start a conversion from shutdown or back to back in continuous mode
	always_comb begin
		conv_start = 1'b0;
		unique case (state_r)
			ADCSC_SHUTDOWN: begin
				conv_start = !mode_single || start_req;
			end
			ADCSC_CONVERT: begin
				conv_start = conv_done && !mode_single;
			end
		endcase
	end

	// Sequencer state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= ADCSC_SHUTDOWN;
		end else if (conv_start) begin
			state_r <= ADCSC_CONVERT;
		end else if (conv_done) begin
			state_r <= ADCSC_SHUTDOWN;
		end
	end

	// Result register holds the newest completed code
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			result_r <= 16'h0000;
		end else if (conv_done) begin
			result_r <= conv_code;
		end
	end

	// Conversion core filter
	adcsc_filter #(
		.CNT_W (32)
	) u_filter (
		.hclk    (hclk),
		.hresetn (hresetn),
		.start   (conv_start),
		.period  (dr_cyc),
		.mod_bit (mod_bit),
		.done    (conv_done),
		.code    (conv_code)
	);

	// Sticky events; a new event wins over a write-one clear
	assign ev[`ADCSC_ST_DONE] = conv_done;
	assign ev[`ADCSC_ST_TMO]  = tmo && xfer_act_r;
	assign ev[`ADCSC_ST_XFER] = cfg_load;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_r <= '0;
			mask_r   <= '0;
		end else begin
			status_r <= ev | (status_r & ~(wr_status ? hwdata[2:0] : 3'h0));
			if (wr_mask) begin
				mask_r <= hwdata[2:0];
			end
		end
	end

	// Level interrupt while any unmasked event is pending
	assign irq = |(status_r & mask_r);

endmodule : adcsc_top

// ---- dv/adcsc_assertions.sv ----
// Port checker of the serial conversion control block.
// Assumes it is bound to adcsc_top and sees only its ports.
`timescale 1ns/1ps
module adcsc_checker (
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Serial pins and outputs
	input wire logic        cs_n,
	input wire logic        data_out_ready_n,
	input wire logic        data_out_oe,
	input wire logic [2:0]  gain_select,
	input wire logic [2:0]  input_channel_select,
	input wire logic        power_down,
	input wire logic        irq
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Bus request decode
	wire rd_req  = hsel && hready && htrans[1] && !hwrite;
	wire any_req = hsel && htrans[1];
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus stalled or error");
	a_oe_off: assert property (cs_n[*6] |-> !data_out_oe && data_out_ready_n)
		else $error("pin driven while deselected");
	a_oe_on: assert property ((!cs_n)[*6] |-> data_out_oe)
		else $error("pin not driven while selected");
	a_idle_high: assert property (!data_out_oe |-> data_out_ready_n)
		else $error("released pin not high");
	a_reset_vals: assert property ($rose(hresetn) |-> power_down
		&& gain_select == 3'b010 && input_channel_select == 3'b000 && !irq)
		else $error("bad values after reset");
	a_unmapped_zero: assert property (rd_req && haddr[7:0] > 8'h10
		|=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_upper_zero: assert property (rd_req |=> hrdata[31:16] == 16'h0)
		else $error("read data upper half set");
	a_rd_hold: assert property (!rd_req |=> $stable(hrdata))
		else $error("read data moved without read");
	a_cfg_stable: assert property ((cs_n && !any_req)[*4] |=>
		$stable(gain_select) && $stable(input_channel_select))
		else $error("config fields moved without cause");
	// Main scenarios reached
	c_irq: cover property (irq);
	c_ready: cover property (data_out_oe && !data_out_ready_n);
	c_run: cover property (!power_down);
endmodule : adcsc_checker

// ---- dv/adcsc_host_model.sv ----
// Host serial controller: frames transfers, shifts config in, result out.
// Assumes the bench calls its tasks; the pin may be released.
`timescale 1ns/1ps
module adcsc_host_model (
	// Serial pins
	output logic      sclk,
	output logic      cs_n,
	output logic      din,
	input  wire logic data_out_ready_n,
	input  wire logic data_out_oe
);
	logic last_r;
	// Released pin shows the inverse of its last driven level
	wire pin = data_out_oe ? data_out_ready_n : ~last_r;
	always @* if (data_out_oe) last_r = data_out_ready_n;
	// Idle: deselected, clock parked low
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
		last_r = 1'b1;
	end
	// One frame of n bits; rdy is the pin before the first clock
	task automatic xfer(input logic [15:0] w, input int n,
		output logic [15:0] r, output logic rdy);
		r = 16'h0;
		#13;
		if (cs_n) begin
			cs_n = 1'b0;
			#400;
		end
		rdy = pin;
		for (int i = 15; i > 15 - n; i--) begin
			sclk = 1'b1;
			din = w[i];
			#200 sclk = 1'b0;
			#100 r[i] = pin;
			#100;
		end
	endtask : xfer
	// Close the frame and keep select high a while
	task automatic frame_end();
		#400 cs_n = 1'b1;
		#400;
	endtask : frame_end
endmodule : adcsc_host_model

// ---- dv/tb_adc_serial_conversion_control.sv ----
// Bench of the serial conversion control block: bus tasks, host model
// on the serial pins, random config words. Assumes shortened counts.
`timescale 1ns/1ps
module tb_adc_serial_conversion_control;
	localparam int DRC[8] = '{32800, 32800, 40, 48, 56, 64, 72, 80};
	localparam int TO_CYC = 200;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
	logic        sclk, cs_n, din, data_out_ready_n, data_out_oe;
	logic        mod_bit, power_down, rdy;
	logic [1:0]  htrans;
	logic [2:0]  gain_select, input_channel_select;
	logic [15:0] w, res;
	logic [31:0] haddr, hwdata, hrdata, rd, seed;
	int          bad_count, total_checks;
	adcsc_top #(.SCLK_TO_CYC(TO_CYC), .DR0_CYC(DRC[0]), .DR1_CYC(DRC[1]),
		.DR2_CYC(DRC[2]), .DR3_CYC(DRC[3]), .DR4_CYC(DRC[4]),
		.DR5_CYC(DRC[5]), .DR6_CYC(DRC[6]), .DR7_CYC(DRC[7])) adcsc_top_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .sclk(sclk), .cs_n(cs_n),
		.din(din), .data_out_ready_n(data_out_ready_n),
		.data_out_oe(data_out_oe), .mod_bit(mod_bit),
		.gain_select(gain_select),
		.input_channel_select(input_channel_select),
		.power_down(power_down), .irq(irq));
	adcsc_host_model adcsc_host_model_i (.sclk(sclk), .cs_n(cs_n),
		.din(din), .data_out_ready_n(data_out_ready_n),
		.data_out_oe(data_out_oe));
	// Clock and watchdog
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	initial begin
		repeat (80000) @(posedge hclk);
		bad_count++;
		give_verdict();
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Saturated sum of a constant modulator level over n cycles
	function automatic logic [15:0] exp_code(input int n, input logic m);
		if (n > 32767)
			return m ? 16'h7fff : 16'h8000;
		return m ? 16'(n) : 16'(-n);
	endfunction : exp_code
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// One single transfer; entered just after a rising edge
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic wait_irq(input int n);
		int k;
		k = 0;
		while (irq !== 1'b1 && k < n) begin
			@(posedge hclk);
			k++;
		end
		chk(irq, 1'b1);
	endtask : wait_irq
	task automatic give_verdict();
		if (bad_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	// Main sequence
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{bad_count, total_checks} = '0;
		mod_bit = 1'b1;
		seed = 32'h68e3;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		bus(0, 8'h00, 0, rd);
		chk(rd, 32'h0580);
		bus(0, 8'h10, 0, rd);
		chk(rd[1], 1'b1);
		bus(0, 8'h20, 0, rd);
		chk(rd, 32'h0);
		bus(1, 8'h0c, 32'h1, rd);
		// Single-shot at every rate, both signs and saturation ends
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			w = {1'b1, seed[5:0], 1'b1, 3'(i), 5'h0};
			mod_bit <= ~i[0];
			bus(1, 8'h00, {16'h0, w}, rd);
			wait_irq(DRC[i] + 40);
			bus(0, 8'h04, 0, rd);
			chk(rd, {16'h0, exp_code(DRC[i], ~i[0])});
			bus(0, 8'h10, 0, rd);
			chk(rd[1], 1'b1);
			chk({gain_select, input_channel_select}, {w[11:9], w[14:12]});
			bus(1, 8'h08, 32'h7, rd);
			@(posedge hclk);
			chk(irq, 1'b0);
		end
		res = exp_code(DRC[7], 1'b0);
		bus(1, 8'h04, 32'h1234, rd);
		bus(0, 8'h04, 0, rd);
		chk(rd, {16'h0, res});
		// Serial read of the newest result, config loaded by the link
		seed = lfsr(seed);
		w = {1'b0, seed[5:0], 1'b1, 3'd2, seed[10:6]};
		adcsc_host_model_i.xfer(w, 16, rd[15:0], rdy);
		chk(rd[15:0], res);
		chk(rdy, 1'b0);
		adcsc_host_model_i.frame_end();
		@(posedge hclk);
		bus(0, 8'h00, 0, rd);
		chk(rd, {16'h0, w});
		chk(input_channel_select, w[14:12]);
		bus(0, 8'h08, 0, rd);
		chk(rd[2], 1'b1);
		chk(irq, 1'b0);
		bus(1, 8'h0c, 32'h4, rd);
		@(posedge hclk);
		chk(irq, 1'b1);
		bus(1, 8'h08, 32'h4, rd);
		@(posedge hclk);
		chk(irq, 1'b0);
		bus(1, 8'h0c, 32'h1, rd);
		// Start request over the link, ready already consumed
		mod_bit <= 1'b1;
		w = {1'b1, seed[16:11], 1'b1, 3'd3, 5'h0};
		adcsc_host_model_i.xfer(w, 16, rd[15:0], rdy);
		chk(rdy, 1'b1);
		adcsc_host_model_i.frame_end();
		wait_irq(DRC[3] + 40);
		@(posedge hclk);
		bus(0, 8'h04, 0, rd);
		chk(rd, {16'h0, exp_code(DRC[3], 1'b1)});
		bus(1, 8'h08, 32'h7, rd);
		// Abandoned frame: clock parked low past the limit
		adcsc_host_model_i.xfer(16'hffff, 5, rd[15:0], rdy);
		repeat (TO_CYC + 20) @(posedge hclk);
		bus(0, 8'h08, 0, rd);
		chk(rd[1], 1'b1);
		seed = lfsr(seed);
		w = {1'b0, seed[5:0], 1'b1, 3'd4, 5'h0};
		adcsc_host_model_i.xfer(w, 16, rd[15:0], rdy);
		adcsc_host_model_i.frame_end();
		@(posedge hclk);
		bus(0, 8'h00, 0, rd);
		chk(rd, {16'h0, w});
		// Continuous: restarts unasked, period follows the rate
		bus(1, 8'h08, 32'h7, rd);
		bus(1, 8'h00, 32'h8060, rd);
		wait_irq(DRC[3] + 40);
		@(posedge hclk);
		bus(1, 8'h00, 32'h0080, rd);
		repeat (2) begin
			bus(1, 8'h08, 32'h1, rd);
			@(posedge hclk);
			wait_irq(DRC[3] + DRC[4] + 40);
			@(posedge hclk);
		end
		bus(0, 8'h04, 0, rd);
		chk(rd, {16'h0, exp_code(DRC[4], 1'b1)});
		bus(0, 8'h10, 0, rd);
		chk(rd[1], 1'b0);
		give_verdict();
	end
endmodule : tb_adc_serial_conversion_control

bind adcsc_top adcsc_checker adcsc_checker_i (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .cs_n(cs_n),
	.data_out_ready_n(data_out_ready_n), .data_out_oe(data_out_oe),
	.gain_select(gain_select), .input_channel_select(input_channel_select),
	.power_down(power_down), .irq(irq));
